/* File: rtl/ilv_pkg.sv */
package ilv_pkg;
  // register indices in the special purpose data memory window
  localparam logic [2:0] ILV_IDX_EDGE = 3'h0;
  localparam logic [2:0] ILV_IDX_CTRL_A = 3'h1;
  localparam logic [2:0] ILV_IDX_CTRL_B = 3'h2;
  localparam logic [2:0] ILV_IDX_CTRL_C = 3'h3;
  localparam logic [2:0] ILV_IDX_GRP0 = 3'h4;
  localparam logic [2:0] ILV_IDX_GRP1 = 3'h5;
  localparam logic [2:0] ILV_IDX_GRP2 = 3'h6;
  localparam logic [2:0] ILV_IDX_LVD = 3'h7;
  localparam logic [7:0] ILV_RESET_VAL = 8'h00;
  // field positions
  localparam int ILV_A_NVF = 6;
  localparam int ILV_A_LVF = 5;
  localparam int ILV_A_EXF = 4;
  localparam int ILV_A_NVE = 3;
  localparam int ILV_A_LVE = 2;
  localparam int ILV_A_EXE = 1;
  localparam int ILV_A_GIE = 0;
  localparam int ILV_B_TIMEBASE0_REQ_FLAG = 7;
  localparam int ILV_B_GRPF = 4;
  localparam int ILV_B_TIMEBASE0_INT_ENABLE = 3;
  localparam int ILV_B_GRPE = 0;
  localparam int ILV_C_SPF = 6;
  localparam int ILV_C_UAF = 5;
  localparam int ILV_C_TIMEBASE1_REQ_FLAG = 4;
  localparam int ILV_C_SPE = 2;
  localparam int ILV_C_UAE = 1;
  localparam int ILV_C_TIMEBASE1_INT_ENABLE = 0;
  localparam int ILV_G_CMPF = 5;
  localparam int ILV_G_PERF = 4;
  localparam int ILV_G_CMPE = 1;
  localparam int ILV_G_PERE = 0;
  localparam int ILV_L_FLAG = 5;
  localparam int ILV_L_EN = 4;
  localparam int ILV_L_BG = 3;
  localparam logic [1:0] ILV_EDGE_OFF = 2'h0;
  localparam logic [1:0] ILV_EDGE_RISE = 2'h1;
  localparam logic [1:0] ILV_EDGE_FALL = 2'h2;
  localparam logic [1:0] ILV_EDGE_BOTH = 2'h3;
  localparam logic [2:0] ILV_THR_PIN = 3'h0;
  // interrupt delay after the flag rises, in ns, and its cycle count
  localparam int ILV_IRQ_DELAY_NS = 1000;
  localparam int ILV_CLK_PERIOD_NS = 25;
  localparam int ILV_IRQ_DELAY_CYC =
    (ILV_IRQ_DELAY_NS + ILV_CLK_PERIOD_NS - 1) / ILV_CLK_PERIOD_NS;
  localparam int ILV_DEB_CYC = 3;
  // vector numbers, lowest number highest priority
  localparam logic [3:0] ILV_VEC_EXT = 4'h0;
  localparam logic [3:0] ILV_VEC_GRP0 = 4'h1;
  localparam logic [3:0] ILV_VEC_GRP1 = 4'h2;
  localparam logic [3:0] ILV_VEC_GRP2 = 4'h3;
  localparam logic [3:0] ILV_VEC_TB0 = 4'h4;
  localparam logic [3:0] ILV_VEC_TB1 = 4'h5;
  localparam logic [3:0] ILV_VEC_LVD = 4'h6;
  localparam logic [3:0] ILV_VEC_NVD = 4'h7;
  localparam logic [3:0] ILV_VEC_UART = 4'h8;
  localparam logic [3:0] ILV_VEC_SPI = 4'h9;
  typedef struct packed {
    logic [2:0] period_match;
    logic [2:0] compare_match;
    logic tb0;
    logic tb1;
    logic nvdata;
    logic serial_periph;
    logic async_serial;
  } ilv_events_type;
  typedef struct packed {
    logic req;
    logic [3:0] vec;
  } ilv_irq_type;
endpackage

/* File: rtl/ilv_ctrl.sv */
`timescale 1ns/10ps
// Summary of operation
// - two-bit edge field: off, rising, falling or both edges on the pin.
// - first control register holds nvdata, undervolt and pin flags at 6,5,4.
// - first control register enables at 3..0, bit 0 the global enable.
// - second register: time base 0 flag bit 7, group flags bits 6..4.
// - second register: time base 0 enable bit 3, group enables bits 2..0.
// - unused bits read zero; all control bits reset to zero.
// - groups gather period and compare match requests, each flag and enable.
// - seven interrupt registers plus the detector register, program visible.
// - threshold field picks one of eight levels, 001..111 supply thresholds.
// - threshold code 000 compares the external sense pin to 1.23V.
// - read-only undervolt flag at bit 5, one when below threshold.
// - detector enable bit 4 switches the detector circuits on and off.
// - bandgap on when detector running, low voltage reset or bandgap bit enabled.
// - detector is forced off while in sleep.
// - detector interrupt input is debounced on the slow internal clock.
// - undervolt request flag set only after a fixed delay past rising.
// - undervolt request wakes from idle; preset flag prevents the wake.
// - flags set regardless of enables, except second register group flags (need an enabled match); dispatch needs source and global.
// - servicing clears the global enable; later events still latch.
// - no acknowledge while the return stack is full.
module ilv_ctrl
  import ilv_pkg::*;
#(
  parameter int IRQ_DELAY_CYC = ILV_IRQ_DELAY_CYC,
  parameter int DEB_CYC = ILV_DEB_CYC
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic sel_i,
  input wire logic wr_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic ext_int_pin_i,
  input wire logic cmp_undervolt_i,
  input wire logic slow_internal_osc_i,
  input wire logic lvr_enable_i,
  input wire logic sleep_i,
  input wire logic idle_i,
  input wire logic stack_full_i,
  input wire logic ack_i,
  input wire ilv_events_type events_i,
  output ilv_irq_type irq_o,
  output logic wake_o,
  output logic detector_on_o,
  output logic bandgap_on_o,
  output logic sense_pin_sel_o,
  output logic [2:0] threshold_select_o
);
  if (IRQ_DELAY_CYC < 1 || IRQ_DELAY_CYC > 65535 || DEB_CYC < 1 ||
      DEB_CYC > 255) begin : g_bad_delay
    $error("ilv_ctrl: unsupported delay parameters");
  end

  logic [1:0] edge_reg, edge_next;
  logic [7:0] ctrl_a_reg, ctrl_a_next;
  logic [7:0] ctrl_b_reg, ctrl_b_next;
  logic [7:0] ctrl_c_reg, ctrl_c_next;
  logic [3:0] grp_reg [3], grp_next [3];
  logic [4:0] lvd_reg, lvd_next;
  logic [7:0] rdata_reg, rdata_next;
  ilv_irq_type irq_reg, irq_next;
  logic wake_reg, wake_next;
  logic [2:0] pin_sync_reg, pin_sync_next;
  logic [1:0] cmp_sync_reg, cmp_sync_next;
  logic [2:0] osc_sync_reg, osc_sync_next;
  logic [7:0] deb_cnt_reg, deb_cnt_next;
  logic deb_reg, deb_next;
  logic [15:0] dly_cnt_reg, dly_cnt_next;
  logic uv_flag;
  logic osc_tick;
  logic pin_rise, pin_fall, pin_evt, lv_evt;
  logic [2:0] grp_pend;
  logic [9:0] pend;
  logic wr_a, wr_b, wr_c;
  logic det_on_next, bg_on_next, pin_sel_next;

  assign wr_a = sel_i && wr_i && (addr_i == ILV_IDX_CTRL_A);
  assign wr_b = sel_i && wr_i && (addr_i == ILV_IDX_CTRL_B);
  assign wr_c = sel_i && wr_i && (addr_i == ILV_IDX_CTRL_C);
  // flag from the comparator only while detector runs
  assign uv_flag = cmp_sync_reg[1] && lvd_reg[ILV_L_EN] && !sleep_i;
  assign osc_tick = osc_sync_reg[1] && !osc_sync_reg[2];
  // edge compare of synchronized pin level
  assign pin_rise = pin_sync_reg[1] && !pin_sync_reg[2];
  assign pin_fall = !pin_sync_reg[1] && pin_sync_reg[2];
  always_comb begin
    case (edge_reg)
      ILV_EDGE_OFF: pin_evt = 1'b0;
      ILV_EDGE_RISE: pin_evt = pin_rise;
      ILV_EDGE_FALL: pin_evt = pin_fall;
      ILV_EDGE_BOTH: pin_evt = pin_rise || pin_fall;
      default: pin_evt = 1'b0;
    endcase
  end
  // request fires when the delay count reaches IRQ_DELAY_CYC - 1, one below where it stops
  assign lv_evt = deb_reg && (dly_cnt_reg == 16'(IRQ_DELAY_CYC - 1));

  // synchronisers, debounce and delay
  always_comb begin
    pin_sync_next = {pin_sync_reg[1:0], ext_int_pin_i};
    cmp_sync_next = {cmp_sync_reg[0], cmp_undervolt_i};
    osc_sync_next = {osc_sync_reg[1:0], slow_internal_osc_i};
    deb_cnt_next = deb_cnt_reg;
    deb_next = deb_reg;
    // level must hold DEB_CYC slow ticks to change the debounced copy
    if (uv_flag == deb_reg) begin
      deb_cnt_next = 8'h00;
    end else if (osc_tick) begin
      if (deb_cnt_reg == 8'(DEB_CYC - 1)) begin
        deb_next = uv_flag;
        deb_cnt_next = 8'h00;
      end else begin
        deb_cnt_next = deb_cnt_reg + 8'h01;
      end
    end
    // count from debounced rise, stops after one request
    if (!deb_reg) begin
      dly_cnt_next = 16'h0000;
    end else if (dly_cnt_reg != 16'(IRQ_DELAY_CYC)) begin
      dly_cnt_next = dly_cnt_reg + 16'h0001;
    end else begin
      dly_cnt_next = dly_cnt_reg;
    end
  end

  always_ff @(posedge mclk_i) begin
    // pin chain runs through reset so no false edge follows it
    pin_sync_reg <= pin_sync_next;
    if (sys_rst_i) begin
      cmp_sync_reg <= 2'h0;
      osc_sync_reg <= 3'h0;
      deb_cnt_reg <= 8'h00;
      deb_reg <= 1'b0;
      dly_cnt_reg <= 16'h0000;
    end else begin
      cmp_sync_reg <= cmp_sync_next;
      osc_sync_reg <= osc_sync_next;
      deb_cnt_reg <= deb_cnt_next;
      deb_reg <= deb_next;
      dly_cnt_reg <= dly_cnt_next;
    end
  end

  // group pending: any enabled period or compare match flag
  for (genvar g = 0; g < 3; g++) begin : g_grp
    assign grp_pend[g] = (grp_reg[g][ILV_G_PERF-2] && grp_reg[g][0]) ||
                         (grp_reg[g][ILV_G_CMPF-2] && grp_reg[g][1]);
  end

  // pending vector list in priority order, bit 0 highest
  assign pend = {
    ctrl_c_reg[ILV_C_SPF] && ctrl_c_reg[ILV_C_SPE],
    ctrl_c_reg[ILV_C_UAF] && ctrl_c_reg[ILV_C_UAE],
    ctrl_a_reg[ILV_A_NVF] && ctrl_a_reg[ILV_A_NVE],
    ctrl_a_reg[ILV_A_LVF] && ctrl_a_reg[ILV_A_LVE],
    ctrl_c_reg[ILV_C_TIMEBASE1_REQ_FLAG] && ctrl_c_reg[ILV_C_TIMEBASE1_INT_ENABLE],
    ctrl_b_reg[ILV_B_TIMEBASE0_REQ_FLAG] && ctrl_b_reg[ILV_B_TIMEBASE0_INT_ENABLE],
    ctrl_b_reg[ILV_B_GRPF+2] && ctrl_b_reg[ILV_B_GRPE+2],
    ctrl_b_reg[ILV_B_GRPF+1] && ctrl_b_reg[ILV_B_GRPE+1],
    ctrl_b_reg[ILV_B_GRPF] && ctrl_b_reg[ILV_B_GRPE],
    ctrl_a_reg[ILV_A_EXF] && ctrl_a_reg[ILV_A_EXE]
  };

  always_comb begin
    edge_next = edge_reg;
    ctrl_a_next = ctrl_a_reg;
    ctrl_b_next = ctrl_b_reg;
    ctrl_c_next = ctrl_c_reg;
    lvd_next = lvd_reg;
    for (int g = 0; g < 3; g++) begin
      grp_next[g] = grp_reg[g];
    end
    if (sel_i && wr_i) begin
      case (addr_i)
        ILV_IDX_EDGE: edge_next = wdata_i[1:0];
        ILV_IDX_CTRL_A: ctrl_a_next = {1'b0, wdata_i[6:0]};
        ILV_IDX_CTRL_B: ctrl_b_next = wdata_i;
        ILV_IDX_CTRL_C: ctrl_c_next = {1'b0, wdata_i[6:4], 1'b0,
                                       wdata_i[2:0]};
        ILV_IDX_GRP0: grp_next[0] = {wdata_i[5:4], wdata_i[1:0]};
        ILV_IDX_GRP1: grp_next[1] = {wdata_i[5:4], wdata_i[1:0]};
        ILV_IDX_GRP2: grp_next[2] = {wdata_i[5:4], wdata_i[1:0]};
        ILV_IDX_LVD: lvd_next = wdata_i[4:0];
        default: edge_next = edge_reg;
      endcase
    end
    // service acknowledge clears global enable and auto flags
    if (ack_i && irq_reg.req) begin
      ctrl_a_next[ILV_A_GIE] = 1'b0;
      case (irq_reg.vec)
        ILV_VEC_EXT: ctrl_a_next[ILV_A_EXF] = 1'b0;
        ILV_VEC_GRP0: ctrl_b_next[ILV_B_GRPF] = 1'b0;
        ILV_VEC_GRP1: ctrl_b_next[ILV_B_GRPF+1] = 1'b0;
        ILV_VEC_GRP2: ctrl_b_next[ILV_B_GRPF+2] = 1'b0;
        ILV_VEC_TB0: ctrl_b_next[ILV_B_TIMEBASE0_REQ_FLAG] = 1'b0;
        ILV_VEC_TB1: ctrl_c_next[ILV_C_TIMEBASE1_REQ_FLAG] = 1'b0;
        ILV_VEC_LVD: ctrl_a_next[ILV_A_LVF] = 1'b0;
        ILV_VEC_NVD: ctrl_a_next[ILV_A_NVF] = 1'b0;
        ILV_VEC_UART: ctrl_c_next[ILV_C_UAF] = 1'b0;
        ILV_VEC_SPI: ctrl_c_next[ILV_C_SPF] = 1'b0;
        default: ctrl_a_next[ILV_A_GIE] = 1'b0;
      endcase
    end
    // events set flags last so a set beats a clear
    if (pin_evt) ctrl_a_next[ILV_A_EXF] = 1'b1;
    if (lv_evt) ctrl_a_next[ILV_A_LVF] = 1'b1;
    if (events_i.nvdata) ctrl_a_next[ILV_A_NVF] = 1'b1;
    if (events_i.tb0) ctrl_b_next[ILV_B_TIMEBASE0_REQ_FLAG] = 1'b1;
    if (events_i.tb1) ctrl_c_next[ILV_C_TIMEBASE1_REQ_FLAG] = 1'b1;
    if (events_i.serial_periph) ctrl_c_next[ILV_C_SPF] = 1'b1;
    if (events_i.async_serial) ctrl_c_next[ILV_C_UAF] = 1'b1;
    for (int g = 0; g < 3; g++) begin
      if (events_i.period_match[g]) grp_next[g][2] = 1'b1;
      if (events_i.compare_match[g]) grp_next[g][3] = 1'b1;
      // group flag follows an enabled pending timer request
      if (grp_pend[g]) ctrl_b_next[ILV_B_GRPF+g] = 1'b1;
    end
  end

  always_comb begin
    case (addr_i)
      ILV_IDX_EDGE: rdata_next = {6'h00, edge_reg};
      ILV_IDX_CTRL_A: rdata_next = ctrl_a_reg;
      ILV_IDX_CTRL_B: rdata_next = ctrl_b_reg;
      ILV_IDX_CTRL_C: rdata_next = ctrl_c_reg;
      ILV_IDX_GRP0: rdata_next = {2'h0, grp_reg[0][3:2], 2'h0,
                                  grp_reg[0][1:0]};
      ILV_IDX_GRP1: rdata_next = {2'h0, grp_reg[1][3:2], 2'h0,
                                  grp_reg[1][1:0]};
      ILV_IDX_GRP2: rdata_next = {2'h0, grp_reg[2][3:2], 2'h0,
                                  grp_reg[2][1:0]};
      ILV_IDX_LVD: rdata_next = {2'h0, uv_flag, lvd_reg};
      default: rdata_next = 8'h00;
    endcase
    irq_next.req = 1'b0;
    irq_next.vec = 4'h0;
    // highest priority enabled request, global gate
    for (int i = 9; i >= 0; i--) begin
      if (pend[i]) begin
        irq_next.vec = 4'(i);
      end
    end
    irq_next.req = (pend != 10'h000) && ctrl_a_next[ILV_A_GIE] &&
                   !stack_full_i && !(ack_i && irq_reg.req);
    // new undervolt request wakes from idle; preset flag blocks it
    wake_next = idle_i && lv_evt && !ctrl_a_reg[ILV_A_LVF];
    det_on_next = lvd_next[ILV_L_EN] && !sleep_i;
    bg_on_next = det_on_next || lvr_enable_i || lvd_next[ILV_L_BG];
    pin_sel_next = lvd_next[2:0] == ILV_THR_PIN;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      edge_reg <= 2'h0;
      ctrl_a_reg <= ILV_RESET_VAL;
      ctrl_b_reg <= ILV_RESET_VAL;
      ctrl_c_reg <= ILV_RESET_VAL;
      for (int g = 0; g < 3; g++) begin
        grp_reg[g] <= 4'h0;
      end
      lvd_reg <= 5'h00;
      rdata_reg <= ILV_RESET_VAL;
      irq_reg <= '0;
      wake_reg <= 1'b0;
    end else begin
      edge_reg <= edge_next;
      ctrl_a_reg <= ctrl_a_next;
      ctrl_b_reg <= ctrl_b_next;
      ctrl_c_reg <= ctrl_c_next;
      for (int g = 0; g < 3; g++) begin
        grp_reg[g] <= grp_next[g];
      end
      lvd_reg <= lvd_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      wake_reg <= wake_next;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      detector_on_o <= 1'b0;
      bandgap_on_o <= 1'b0;
      sense_pin_sel_o <= 1'b0;
      threshold_select_o <= 3'h0;
    end else begin
      detector_on_o <= det_on_next;
      bandgap_on_o <= bg_on_next;
      sense_pin_sel_o <= pin_sel_next;
      threshold_select_o <= lvd_next[2:0];
    end
  end

  assign rdata_o = rdata_reg;
  assign irq_o = irq_reg;
  assign wake_o = wake_reg;

  chk_ack_clears_gie: assert property (@(posedge mclk_i)
    disable iff (sys_rst_i) (ack_i && irq_reg.req && !wr_a)
    |=> !ctrl_a_reg[ILV_A_GIE]) else $error("global enable not cleared");
  chk_stack_full_block: assert property (@(posedge mclk_i)
    disable iff (sys_rst_i) stack_full_i |=> !irq_reg.req)
    else $error("request while stack full");
  chk_pin_flag_set: assert property (@(posedge mclk_i)
    disable iff (sys_rst_i) pin_evt |=> ctrl_a_reg[ILV_A_EXF])
    else $error("pin flag not set");
  chk_edge_off: assert property (@(posedge mclk_i)
    disable iff (sys_rst_i) (edge_reg == ILV_EDGE_OFF && !wr_a &&
    !ctrl_a_reg[ILV_A_EXF]) |=> !ctrl_a_reg[ILV_A_EXF])
    else $error("pin flag set with edge off");
  chk_no_gie_no_irq: assert property (@(posedge mclk_i)
    disable iff (sys_rst_i) (!ctrl_a_reg[ILV_A_GIE] && !wr_a) |=> !irq_reg.req)
    else $error("request without global enable");
  chk_sleep_off: assert property (@(posedge mclk_i)
    disable iff (sys_rst_i) sleep_i |=> !detector_on_o)
    else $error("detector on in sleep");
  chk_bandgap_on: assert property (@(posedge mclk_i)
    disable iff (sys_rst_i) lvr_enable_i |=> bandgap_on_o)
    else $error("bandgap off with reset enabled");
  chk_lvf_delay: assert property (@(posedge mclk_i)
    disable iff (sys_rst_i) $rose(lv_evt) |-> $past(deb_reg, 1))
    else $error("undervolt request without delay");
  chk_unused_zero: assert property (@(posedge mclk_i)
    disable iff (sys_rst_i) !ctrl_a_reg[7] && !ctrl_c_reg[7] &&
    !ctrl_c_reg[3]) else $error("unused bit set");
endmodule

/* File: sim/ilv_core_model.sv */
`timescale 1ns/10ps
module ilv_core_model
  import ilv_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire ilv_irq_type irq_i,
  input wire logic [3:0] ack_wait_i,
  output logic ack_o,
  output logic [3:0] last_vec_o,
  output logic [7:0] acks_o
);
  logic [3:0] cnt_reg;
  logic [1:0] hold_reg;
  // request is still up the cycle after an ack, so hold off a while
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ack_o <= 1'b0;
      cnt_reg <= 4'h0;
      hold_reg <= 2'h0;
      acks_o <= 8'h00;
      last_vec_o <= 4'h0;
    end else if (hold_reg != 2'h0) begin
      ack_o <= 1'b0;
      hold_reg <= hold_reg - 2'h1;
    end else if (irq_i.req && cnt_reg >= ack_wait_i) begin
      ack_o <= 1'b1;
      last_vec_o <= irq_i.vec;
      acks_o <= acks_o + 8'h01;
      cnt_reg <= 4'h0;
      hold_reg <= 2'h3;
    end else if (irq_i.req) begin
      ack_o <= 1'b0;
      cnt_reg <= cnt_reg + 4'h1;
    end else begin
      ack_o <= 1'b0;
      cnt_reg <= 4'h0;
    end
  end
endmodule

/* File: sim/interrupt_and_lowvolt_flags_test.sv */
`timescale 1ns/10ps
module interrupt_and_lowvolt_flags_test
  import ilv_pkg::*;
;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic sel_i = 1'b0;
  logic wr_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic ext_int_pin_i = 1'b0;
  logic cmp_undervolt_i = 1'b0;
  logic slow_internal_osc_i = 1'b0;
  logic lvr_enable_i = 1'b0;
  logic sleep_i = 1'b0;
  logic idle_i = 1'b0;
  logic stack_full_i = 1'b0;
  ilv_events_type events_i = '0;
  ilv_events_type ev;
  logic ack_i;
  logic [7:0] rdata_o;
  ilv_irq_type irq_o;
  logic wake_o, detector_on_o, bandgap_on_o, sense_pin_sel_o;
  logic [2:0] threshold_select_o;
  logic [3:0] last_vec;
  logic [7:0] acks, n;
  logic [3:0] ack_wait = 4'h0;
  logic [3:0] slow_div = 4'h0;
  logic wake_seen = 1'b0;
  int fail_count = 0;
  int comparisons = 0;
  localparam logic [7:0] MASK [8] = '{8'h03, 8'h7f, 8'hff, 8'h77,
    8'h33, 8'h33, 8'h33, 8'h1f};
  localparam logic [2:0] CLR [8] = '{3'h0, 3'h4, 3'h5, 3'h6,
    3'h1, 3'h2, 3'h3, 3'h7};

  ilv_ctrl #(.IRQ_DELAY_CYC(2), .DEB_CYC(1)) dut_u (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .sel_i(sel_i), .wr_i(wr_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .ext_int_pin_i(ext_int_pin_i),
    .cmp_undervolt_i(cmp_undervolt_i),
    .slow_internal_osc_i(slow_internal_osc_i),
    .lvr_enable_i(lvr_enable_i), .sleep_i(sleep_i), .idle_i(idle_i),
    .stack_full_i(stack_full_i), .ack_i(ack_i), .events_i(events_i),
    .irq_o(irq_o), .wake_o(wake_o), .detector_on_o(detector_on_o),
    .bandgap_on_o(bandgap_on_o), .sense_pin_sel_o(sense_pin_sel_o),
    .threshold_select_o(threshold_select_o));
  ilv_core_model core_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .irq_i(irq_o), .ack_wait_i(ack_wait), .ack_o(ack_i),
    .last_vec_o(last_vec), .acks_o(acks));

  always #12.5 mclk_i = ~mclk_i;
  // slow oscillator at a sixteenth of the system clock keeps debounce short
  always @(posedge mclk_i) begin
    slow_div <= slow_div + 4'h1;
    slow_internal_osc_i <= slow_div[3];
    if (wake_o === 1'b1) wake_seen <= 1'b1;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    sel_i <= 1'b1;
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    sel_i <= 1'b0;
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    sel_i <= 1'b1;
    wr_i <= 1'b0;
    addr_i <= a;
    @(posedge mclk_i);
    #1;
    check(rdata_o, exp);
    @(posedge mclk_i);
    sel_i <= 1'b0;
  endtask
  task automatic settle;
    repeat (2) @(posedge mclk_i);
    #1;
  endtask
  task automatic pulse(input ilv_events_type v);
    @(posedge mclk_i) events_i <= v;
    @(posedge mclk_i) events_i <= '0;
  endtask
  task automatic wait_ack(input logic [3:0] v);
    logic [7:0] n0;
    int k;
    n0 = acks;
    k = 0;
    while (acks === n0 && k < 60) begin
      @(posedge mclk_i) #1 k++;
    end
    check(acks, n0 + 8'h01);
    check({4'h0, last_vec}, {4'h0, v});
  endtask
  task automatic wait_wake(input logic exp);
    wake_seen = 1'b0;
    repeat (150) @(posedge mclk_i);
    check({7'h0, wake_seen}, {7'h0, exp});
  endtask
  task automatic results;
    $display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    results();
  end

  initial begin
    repeat (4) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00);
    // stack held full so the all-ones pattern cannot dispatch
    stack_full_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wr(i[2:0], 8'hff);
      rd(i[2:0], MASK[i]);
    end
    settle();
    check({7'h0, detector_on_o}, 8'h01);
    check({5'h0, threshold_select_o}, 8'h07);
    for (int i = 0; i < 8; i++) wr(CLR[i], 8'h00);
    stack_full_i <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(3'h0, i[7:0]);
      @(posedge mclk_i) ext_int_pin_i <= 1'b1;
      repeat (5) @(posedge mclk_i);
      rd(3'h1, {3'h0, i[0], 4'h0});
      wr(3'h1, 8'h00);
      @(posedge mclk_i) ext_int_pin_i <= 1'b0;
      repeat (5) @(posedge mclk_i);
      rd(3'h1, {3'h0, i[1], 4'h0});
      wr(3'h1, 8'h00);
    end
    ev = '0;
    ev.tb0 = 1'b1;
    ev.nvdata = 1'b1;
    pulse(ev);
    rd(3'h1, 8'h40);
    rd(3'h2, 8'h80);
    check({7'h0, irq_o.req}, 8'h00);
    wr(3'h2, 8'h88);
    wr(3'h1, 8'h49);
    wait_ack(ILV_VEC_TB0);
    rd(3'h1, 8'h48);
    rd(3'h2, 8'h08);
    ack_wait <= 4'h4;
    wr(3'h1, 8'h49);
    wait_ack(ILV_VEC_NVD);
    rd(3'h1, 8'h08);
    ev = '0;
    ev.tb0 = 1'b1;
    pulse(ev);
    rd(3'h2, 8'h88);
    stack_full_i <= 1'b1;
    wr(3'h1, 8'h09);
    n = acks;
    repeat (10) @(posedge mclk_i);
    check(acks, n);
    stack_full_i <= 1'b0;
    wait_ack(ILV_VEC_TB0);
    ack_wait <= 4'h0;
    wr(3'h2, 8'h02);
    wr(3'h5, 8'h02);
    ev = '0;
    ev.compare_match = 3'b010;
    ev.period_match = 3'b001;
    pulse(ev);
    rd(3'h5, 8'h22);
    rd(3'h4, 8'h10);
    rd(3'h2, 8'h22);
    wr(3'h1, 8'h01);
    wait_ack(ILV_VEC_GRP1);
    rd(3'h5, 8'h22);
    for (int i = 0; i < 6; i++) wr(CLR[i], 8'h00);
    ev = '0;
    ev.tb1 = 1'b1;
    ev.serial_periph = 1'b1;
    ev.async_serial = 1'b1;
    pulse(ev);
    rd(3'h3, 8'h70);
    wr(3'h3, 8'h77);
    wr(3'h1, 8'h01);
    wait_ack(ILV_VEC_TB1);
    rd(3'h3, 8'h67);
    wr(3'h1, 8'h01);
    wait_ack(ILV_VEC_UART);
    wr(3'h1, 8'h01);
    wait_ack(ILV_VEC_SPI);
    rd(3'h3, 8'h07);
    wr(3'h3, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(3'h7, 8'h10 | i[7:0]);
      settle();
      check({5'h0, threshold_select_o}, i[7:0]);
      check({7'h0, sense_pin_sel_o}, {7'h0, i == 0});
    end
    wr(3'h7, 8'h10);
    settle();
    check({6'h0, detector_on_o, bandgap_on_o}, 8'h03);
    repeat (20) @(posedge mclk_i);
    @(posedge mclk_i) cmp_undervolt_i <= 1'b1;
    rd(3'h1, 8'h00);
    repeat (80) @(posedge mclk_i);
    rd(3'h7, 8'h30);
    rd(3'h1, 8'h20);
    @(posedge mclk_i) sleep_i <= 1'b1;
    settle();
    check({7'h0, detector_on_o}, 8'h00);
    @(posedge mclk_i) sleep_i <= 1'b0;
    @(posedge mclk_i) cmp_undervolt_i <= 1'b0;
    repeat (80) @(posedge mclk_i);
    rd(3'h7, 8'h10);
    wr(3'h7, 8'h00);
    @(posedge mclk_i) lvr_enable_i <= 1'b1;
    settle();
    check({7'h0, bandgap_on_o}, 8'h01);
    @(posedge mclk_i) lvr_enable_i <= 1'b0;
    settle();
    check({7'h0, bandgap_on_o}, 8'h00);
    wr(3'h7, 8'h08);
    settle();
    check({7'h0, bandgap_on_o}, 8'h01);
    wr(3'h7, 8'h10);
    wr(3'h1, 8'h00);
    @(posedge mclk_i) idle_i <= 1'b1;
    cmp_undervolt_i <= 1'b1;
    wait_wake(1'b1);
    @(posedge mclk_i) cmp_undervolt_i <= 1'b0;
    repeat (80) @(posedge mclk_i);
    wr(3'h1, 8'h20);
    @(posedge mclk_i) cmp_undervolt_i <= 1'b1;
    wait_wake(1'b0);
    idle_i <= 1'b0;
    results();
  end
endmodule
